// ### hdl/rs485_enable_pkg.sv
// Constants, types and register map for the line driver enable controller.
// Assumes a single 20 MHz clock and a 32-bit APB register port.
package rs485_enable_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_HZ      = 20_000_000;
    localparam int BAUD_MIN    = 1200;
    localparam int BAUD_MAX    = 115200;
    localparam int FRAME_BITS  = 10;
    localparam int HOLD_BITS   = 2;
    // Longest bit period rounds up, shortest rounds down
    localparam int PERIOD_MAX_CYC = (CLK_HZ + BAUD_MIN - 1) / BAUD_MIN;
    localparam int PERIOD_MIN_CYC = CLK_HZ / BAUD_MAX;
    localparam int GLITCH_CYC     = PERIOD_MIN_CYC / 2;
    localparam int RELEARN_CYC    = 12 * PERIOD_MAX_CYC;
    localparam int EST_W          = 15;
    localparam int CNT_W          = 20;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int          ADDR_W        = 12;
    localparam logic [11:0] REG_CTRL      = 12'h000;
    localparam logic [11:0] REG_STATUS    = 12'h004;
    localparam logic [11:0] REG_PERIOD    = 12'h008;
    localparam int          CTRL_OVR_BIT  = 0;
    localparam int          CTRL_MODE_LSB = 1;
    localparam logic [2:0]  CTRL_RESET    = 3'h0;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_ALWAYS,
        MODE_AUTO,
        MODE_RTS,
        MODE_DATA
    } drive_mode_t;

    typedef struct packed {
        logic data;
        logic oe;
    } line_t;

    typedef struct packed {
        logic        busy;
        logic        oe;
        logic        locked;
        drive_mode_t mode;
    } status_t;

endpackage : rs485_enable_pkg

// ### hdl/rs485_driver_enable_control.sv
// Line driver enable controller with autobaud, RTS and data-gated modes.
// Assumes host serial inputs already synchronous to pclk.
//
// Overview of operation
// - Full-duplex mode keeps driver always enabled
// - Non-transmitting station keeps driver tri-stated
// - Auto mode measures baud and gates driver
// - Up to 38.4K release within 4 bits
// - At 57.6K release within 10 bits
// - At 115.2K release within 20 bits
// - RTS mode drives only while RTS asserted
// - Data mode tri-states on a one bit
// - Data mode drives on a zero bit
// - Data passes at all rates, all modes
`timescale 1ns/1ps
module rs485_driver_enable_control
    import rs485_enable_pkg::*;
#(
    parameter int RELEARN_CYCLES = rs485_enable_pkg::RELEARN_CYC
) (
    input  wire logic                         pclk,    // Clock, 20 MHz
    input  wire logic                         presetn, // Async reset
    input  wire logic                         clk_en,  // State freeze
    input  wire logic                         psel,    // APB select
    input  wire logic                         penable, // APB enable
    input  wire logic                         pwrite,  // APB direction
    input  wire logic [rs485_enable_pkg::ADDR_W-1:0] paddr, // APB addr
    input  wire logic [31:0]                  pwdata,  // APB write data
    output logic      [31:0]                  prdata,  // APB read data
    output logic                              pready,  // APB ready
    output logic                              pslverr, // APB error
    input  wire logic                         txd,     // Host data
    input  wire logic                         rts_req, // Host RTS
    input  wire logic [1:0]                   driver_mode_switch, // Mode
    output rs485_enable_pkg::line_t           line     // Driver pins
);
    import rs485_enable_pkg::*;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    generate
        if (RELEARN_CYCLES < 1 || RELEARN_CYCLES >= (1 << CNT_W)) begin : g_bad
            $error("RELEARN_CYCLES out of counter range");
        end
    endgenerate

    localparam logic [CNT_W-1:0] RELEARN_LIM = CNT_W'(RELEARN_CYCLES);
    localparam logic [EST_W-1:0] EST_MAX     = EST_W'(PERIOD_MAX_CYC);
    localparam logic [EST_W-1:0] EST_GLITCH  = EST_W'(GLITCH_CYC);

    // Period times bit count, kept wide until the final cut
    function automatic logic [CNT_W-1:0] bits_of(
        input logic [EST_W-1:0] period,
        input int unsigned      nbits
    );
        logic [CNT_W+7:0] prod;
        prod    = {8'h00, (CNT_W-EST_W)'(0), period} * (CNT_W+8)'(nbits);
        bits_of = prod[CNT_W-1:0];
    endfunction : bits_of

    // ****************************************************************
    // State
    // ****************************************************************
    logic [2:0]       ctrl;
    drive_mode_t      active_mode;
    logic             txd_q;
    logic             frame_open;
    logic             locked;
    logic [CNT_W-1:0] elapsed;
    logic [EST_W-1:0] run_cnt;
    logic [EST_W-1:0] est;

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire              fall      = txd_q & ~txd;
    wire              edge_seen = txd_q ^ txd;
    // A fall after nine and a half bits is a new start bit
    wire [CNT_W-1:0]  restart_at = bits_of(est, FRAME_BITS - 1)
                                 + CNT_W'(est[EST_W-1:1]);
    wire [CNT_W-1:0]  release_at = bits_of(est, FRAME_BITS + HOLD_BITS);
    wire              past_frame = elapsed >= restart_at;
    wire              close_now  = frame_open & txd & (elapsed >= release_at);
    // Long idle forgets the rate so a slower host can relock
    wire              relearn    = ~frame_open & (elapsed >= RELEARN_LIM);
    wire              run_ok     = frame_open & edge_seen
                                 & (run_cnt >= EST_GLITCH) & (run_cnt < est);
    wire drive_mode_t req_mode   = ctrl[CTRL_OVR_BIT]
                                 ? drive_mode_t'(ctrl[CTRL_MODE_LSB +: 2])
                                 : drive_mode_t'(driver_mode_switch);
    wire              mode_free  = ~frame_open & txd;
    wire              apb_setup  = psel & ~penable;
    wire              apb_write  = psel & penable & pwrite;
    wire              hit_ctrl   = paddr == REG_CTRL;
    wire              hit_status = paddr == REG_STATUS;
    wire              hit_period = paddr == REG_PERIOD;
    wire              mapped     = hit_ctrl | hit_status | hit_period;
    status_t          status;
    logic             next_oe;

    assign status = '{busy: frame_open, oe: line.oe, locked: locked,
                      mode: active_mode};

    always_comb begin
        next_oe = 1'b0;
        unique case (active_mode)
            MODE_ALWAYS: next_oe = 1'b1;
            MODE_AUTO:   next_oe = (frame_open & ~close_now) | fall;
            MODE_RTS:    next_oe = rts_req;
            MODE_DATA:   next_oe = ~txd;
        endcase
    end

    // ****************************************************************
    // APB slave
    // ****************************************************************
    // Registers answer in the access cycle, no wait states
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl   <= CTRL_RESET;
            prdata <= 32'h0000_0000;
        end else if (clk_en) begin
            if (apb_write && hit_ctrl) begin
                ctrl <= pwdata[2:0];
            end
            if (apb_setup) begin
                prdata <= hit_ctrl   ? {29'h0, ctrl} :
                          hit_status ? {27'h0, status} :
                          hit_period ? {17'h0, est} : 32'h0000_0000;
            end
        end
    end

    // ****************************************************************
    // Mode latch
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_mode <= MODE_ALWAYS;
        end else if (clk_en) begin
            if (mode_free) begin
                active_mode <= req_mode;
            end
        end
    end

    // ****************************************************************
    // Frame tracker and baud estimate
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_q      <= 1'b1;
            frame_open <= 1'b0;
            elapsed    <= '0;
            run_cnt    <= '0;
        end else if (clk_en) begin
            txd_q <= txd;
            if (edge_seen) begin
                run_cnt <= '0;
            end else if (run_cnt != EST_MAX) begin
                run_cnt <= run_cnt + EST_W'(1);
            end
            // frames open on a start edge
            if (fall && (!frame_open || past_frame)) begin
                frame_open <= 1'b1;
                elapsed    <= '0;
            end else if (close_now || relearn) begin
                frame_open <= 1'b0;
                elapsed    <= '0;
            end else if (elapsed != '1) begin
                elapsed <= elapsed + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            est    <= EST_MAX;
            locked <= 1'b0;
        end else if (clk_en) begin
            // shortest run is one bit period
            if (relearn) begin
                est    <= EST_MAX;
                locked <= 1'b0;
            end else if (run_ok) begin
                est    <= run_cnt;
                locked <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Line outputs
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line <= '{data: 1'b1, oe: 1'b1};
        end else if (clk_en) begin
            line.data <= txd;
            line.oe   <= next_oe;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // Cycles the driver stays on past its release point
    logic [CNT_W-1:0] over_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            over_cnt <= '0;
        end else if (clk_en) begin
            if (active_mode == MODE_AUTO && line.oe && txd && frame_open
                && elapsed >= release_at && over_cnt != '1) begin
                over_cnt <= over_cnt + CNT_W'(1);
            end else begin
                over_cnt <= '0;
            end
        end
    end

    a_always_on: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(clk_en) && $past(active_mode) == MODE_ALWAYS) |-> line.oe)
        else $error("driver dropped in always mode");

    a_idle_off: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(clk_en) && $past(active_mode) == MODE_AUTO
         && !$past(frame_open) && $past(txd)) |-> !line.oe)
        else $error("driver on while idle in auto mode");

    a_auto_start: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && active_mode == MODE_AUTO && fall) |=> line.oe)
        else $error("start bit not driven in auto mode");

    a_release_bound: assert property (@(posedge pclk)
        disable iff (!presetn) over_cnt <= CNT_W'(2))
        else $error("driver held past hold window");

    a_rts_follow: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(clk_en) && $past(active_mode) == MODE_RTS)
        |-> line.oe == $past(rts_req))
        else $error("driver does not follow RTS");

    a_data_one: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && active_mode == MODE_DATA && txd) |=> !line.oe)
        else $error("driver on for a one bit");

    a_data_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && active_mode == MODE_DATA && !txd)
        |=> (line.oe && !line.data))
        else $error("driver not pulling low for a zero bit");

    a_data_pass: assert property (@(posedge pclk) disable iff (!presetn)
        $past(clk_en) |-> line.data == $past(txd))
        else $error("line data does not follow host data");

    a_mode_static: assert property (@(posedge pclk)
        disable iff (!presetn)
        (active_mode != $past(active_mode)) |-> $past(mode_free && clk_en))
        else $error("mode changed inside a character");

    a_period_floor: assert property (@(posedge pclk)
        disable iff (!presetn)
        est >= EST_GLITCH)
        else $error("bit period estimate below glitch floor");

    a_frame_on: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && active_mode == MODE_AUTO && frame_open && !close_now)
        |=> line.oe)
        else $error("driver dropped inside an open frame");

    a_lock_est: assert property (@(posedge pclk) disable iff (!presetn)
        locked |-> est != EST_MAX)
        else $error("locked with no measured period");

    a_rate_relearn: assert property (@(posedge pclk)
        disable iff (!presetn)
        (clk_en && relearn) |=> (!locked && est == EST_MAX))
        else $error("rate not forgotten after long idle");

    a_rts_idle: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(clk_en) && $past(active_mode) == MODE_RTS && !$past(rts_req))
        |-> !line.oe)
        else $error("driver on while RTS is low");

endmodule : rs485_driver_enable_control

// ### dv/host_uart_model.sv
// Host serial port model: drives txd and rts_req toward the block.
// Assumes the bench clock; changes its lines just after a rising edge.
`timescale 1ns/1ps
module host_uart_model (
    input  wire logic pclk,    // Bench clock
    output logic      txd,     // Serial data, idle high
    output logic      rts_req  // Request to send, active high
);
    initial begin
        txd     = 1'b1;
        rts_req = 1'b0;
    end

    task automatic send_byte(input logic [7:0] b, input int per);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge pclk) txd <= f[i];
            repeat (per - 1) @(posedge pclk);
        end
        @(posedge pclk);
    endtask : send_byte

    task automatic set_rts(input logic v);
        @(posedge pclk) rts_req <= v;
    endtask : set_rts
endmodule : host_uart_model

// ### dv/test_rs485_driver_enable_control.sv
// Self-checking bench for the line driver enable controller.
// Assumes the host model file and the design package are compiled first.
`timescale 1ns/1ps
module test_rs485_driver_enable_control;
    import rs485_enable_pkg::*;
    localparam int RELEARN = 8000;
    logic              pclk, presetn, psel, penable, pwrite;
    logic              pready, pslverr, txd, rts_req;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic [1:0]        mode_sw;
    logic              er;
    logic              clk_en;
    line_t             line_o;
    int                n_errors, samples_checked;

    always #25 pclk = ~pclk;

    rs485_driver_enable_control #(.RELEARN_CYCLES(RELEARN))
        i_rs485_driver_enable_control (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .txd(txd), .rts_req(rts_req),
        .driver_mode_switch(mode_sw), .line(line_o));

    host_uart_model i_host_uart_model (
        .pclk(pclk), .txd(txd), .rts_req(rts_req));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk) penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            n_errors++;
            tally_and_finish;
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_mode(input logic [1:0] m);
        int n;
        n = 0;
        do begin
            apb(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (rd[1:0] !== m && n < 2000);
        check(32'(m), 32'(rd[1:0]));
        if (rd[1:0] !== m) tally_and_finish;
    endtask : wait_mode

    task automatic oe_is(input logic exp);
        repeat (4) @(negedge pclk);
        check(32'(exp), 32'(line_o.oe));
    endtask : oe_is

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic test_regs;
        apb(1'b0, REG_CTRL, 32'h0);
        check(32'(CTRL_RESET), rd);
        apb(1'b1, REG_STATUS, 32'hff);
        check(32'h0, 32'(er));
        apb(1'b0, REG_STATUS, 32'h0);
        check(32'h8, rd);
        apb(1'b0, REG_PERIOD, 32'h0);
        check(32'(PERIOD_MAX_CYC), rd);
        apb(1'b1, 12'h00c, 32'h7);
        check(32'h1, 32'(er));
        apb(1'b0, 12'h00c, 32'h0);
        check(32'h0, rd);
        apb(1'b1, REG_CTRL, 32'h5);
        apb(1'b0, REG_CTRL, 32'h0);
        check(32'h5, rd);
        oe_is(1'b0);
        apb(1'b1, REG_CTRL, 32'h0);
        oe_is(1'b1);
        // Frozen clock enable must drop the write
        @(posedge pclk) clk_en <= 1'b0;
        apb(1'b1, REG_CTRL, 32'h5);
        @(posedge pclk) clk_en <= 1'b1;
        apb(1'b0, REG_CTRL, 32'h0);
        check(32'h0, rd);
        $display("registers done");
    endtask : test_regs

    task automatic test_always;
        int bad;
        bad = 0;
        fork
            i_host_uart_model.send_byte(8'h0f, 174);
            repeat (1700) @(negedge pclk) if (line_o.oe !== 1'b1) bad++;
        join
        check(32'h0, 32'(bad));
        $display("always mode done");
    endtask : test_always

    task automatic test_rts;
        @(posedge pclk) mode_sw <= 2'h2;
        wait_mode(2'h2);
        oe_is(1'b0);
        i_host_uart_model.set_rts(1'b1);
        oe_is(1'b1);
        i_host_uart_model.send_byte(8'h3c, 174);
        i_host_uart_model.set_rts(1'b0);
        oe_is(1'b0);
        $display("rts mode done");
    endtask : test_rts

    task automatic test_data;
        int   bad;
        logic last;
        bad  = 0;
        last = 1'b1;
        @(posedge pclk) mode_sw <= 2'h3;
        wait_mode(2'h3);
        oe_is(1'b0);
        fork
            i_host_uart_model.send_byte(8'h5a, 174);
            repeat (1700) @(negedge pclk) begin
                if (line_o.data !== last || line_o.oe !== ~last) bad++;
                last = txd;
            end
        join
        check(32'h0, 32'(bad));
        $display("data mode done");
    endtask : test_data

    task automatic auto_char(input int per, input int lim, input logic chk);
        int n;
        n = 0;
        fork
            i_host_uart_model.send_byte(8'h55, per);
            begin
                repeat (3 * per) @(posedge pclk);
                mode_sw <= 2'h2;
                oe_is(1'b1);
                @(posedge pclk) mode_sw <= 2'h1;
            end
        join
        while (line_o.oe === 1'b1 && n <= lim) begin
            @(negedge pclk);
            n++;
        end
        if (chk || n > lim) check(32'h1, 32'(n <= lim));
        if (n > lim) tally_and_finish;
    endtask : auto_char

    task automatic test_auto;
        int per[3]  = '{521, 347, 174};
        int bits[3] = '{4, 10, 20};
        @(posedge pclk) mode_sw <= 2'h1;
        wait_mode(2'h1);
        repeat (RELEARN + 100) @(posedge pclk);
        for (int i = 0; i < 3; i++) begin
            auto_char(per[i], 30 * per[i], 1'b0);
            auto_char(per[i], bits[i] * per[i] + 2, 1'b1);
        end
        $display("auto mode done");
    endtask : test_auto

    initial begin
        pclk    = 1'b0;
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = 32'h0;
        mode_sw = 2'h0;
        clk_en  = 1'b1;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        test_regs;
        test_always;
        test_rts;
        test_data;
        test_auto;
        tally_and_finish;
    end
endmodule : test_rs485_driver_enable_control
